/* hdl/pps_map.svh */
// register offsets, field positions, reset values and timing figures
// for the port power enable sequencer; definitions only
`ifndef PPS_MAP_SVH
`define PPS_MAP_SVH

`define PPS_ADDR_W 8
`define PPS_DATA_W 32
`define PPS_REG_CTRL 8'h00
`define PPS_REG_VOUT 8'h04
`define PPS_REG_STATUS 8'h08

`define PPS_CTRL_EN_BIT 0
`define PPS_CTRL_DONE_BIT 1
`define PPS_VOUT_W 10
// output target in 10 mV steps, 5.15 V
`define PPS_VOUT_RST 10'h203

`define PPS_CLK_MHZ 50
`define PPS_MIN_OFF_NS 150
`define PPS_REFRESH_NS 7500
`define PPS_FORCE_NS 60
`define PPS_DETACH_RETRY_US 1000
`define PPS_PERMIT_RETRY_US 1000
`define PPS_GATE_LEAD_NS 200
`define PPS_NS_CYC_UP(ns) ((((ns) * `PPS_CLK_MHZ) + 999) / 1000)
`define PPS_NS_CYC_DN(ns) (((ns) * `PPS_CLK_MHZ) / 1000)
`define PPS_US_CYC(us) ((us) * `PPS_CLK_MHZ)

`endif

/* hdl/pps_pkg.sv */
// types shared by the port power enable sequencer
// assumes pps_map.svh for all numeric figures
package pps_pkg;

	typedef enum logic [2:0] {
		PPS_ST_OFF = 3'b000,
		PPS_ST_IDLE = 3'b001,
		PPS_ST_GATE = 3'b010,
		PPS_ST_RUN = 3'b011,
		PPS_ST_DISCH = 3'b100
	} pps_state_t;

	typedef struct packed {
		logic attach;
		logic pol;
		logic sink_cc1;
		logic sink_cc2;
	} pps_cc_t;

endpackage

/* hdl/pps_retry_timer.sv */
// countdown retry timer; a load keeps the longer of the remaining and new time
// assumes one clock and a synchronised active-low reset
`timescale 1ns/1ps
`default_nettype none

module pps_retry_timer #(
	parameter int W = 20
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic load,
	input wire logic [W-1:0] load_val,
	// status
	output logic busy_ff
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (cnt_ff != '0) begin
			nxt_cnt = cnt_ff - 1'b1;
		end
		if (load && (load_val > nxt_cnt)) begin
			nxt_cnt = load_val;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
			busy_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			busy_ff <= (nxt_cnt != '0);
		end
	end
endmodule // pps_retry_timer

`default_nettype wire

/* hdl/pps_dropout_refresh.sv */
// dropout watch: short low-side on-times held for a whole window force a
// brief low-side pulse once per window
// assumes low_side_on is synchronous to clk
`timescale 1ns/1ps
`default_nettype none

module pps_dropout_refresh #(
	parameter int MIN_OFF_CYC = 8,
	parameter int WINDOW_CYC = 375,
	parameter int FORCE_CYC = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// converter state
	input wire logic active,
	input wire logic low_side_on,
	// forced low-side request
	output logic force_ff
);
	logic prev_ff;
	logic [15:0] on_cnt_ff;
	logic [15:0] win_cnt_ff;
	logic [7:0] frc_cnt_ff;
	logic long_off;
	logic fall;

	assign fall = prev_ff && !low_side_on;
	assign long_off = (on_cnt_ff > 16'(MIN_OFF_CYC)) || (fall && on_cnt_ff > 16'(MIN_OFF_CYC));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_ff <= 1'b0;
			on_cnt_ff <= '0;
		end else begin
			prev_ff <= low_side_on;
			on_cnt_ff <= low_side_on ? on_cnt_ff + 16'h0001 : 16'h0000; // [R12]
		end
	end

	// window of continuous minimum off-time
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			win_cnt_ff <= '0;
		end else if (!active || long_off) begin
			win_cnt_ff <= '0;
		end else if (win_cnt_ff == 16'(WINDOW_CYC - 1)) begin
			win_cnt_ff <= '0;
		end else begin
			win_cnt_ff <= win_cnt_ff + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frc_cnt_ff <= '0;
			force_ff <= 1'b0;
		end else if (!active) begin
			frc_cnt_ff <= '0;
			force_ff <= 1'b0;
		end else if (!long_off && win_cnt_ff == 16'(WINDOW_CYC - 1)) begin
			frc_cnt_ff <= 8'(FORCE_CYC - 1); // [R13]
			force_ff <= 1'b1;
		end else if (frc_cnt_ff != '0) begin
			frc_cnt_ff <= frc_cnt_ff - 8'h01;
		end else begin
			force_ff <= 1'b0;
		end
	end
endmodule // pps_dropout_refresh

`default_nettype wire

/* hdl/pps_sequencer.sv */
// port power enable sequencer: converter permit, attach gating, isolation
// gate and discharge order, cable power feed, unconfigured alert
// assumes all inputs synchronous to ref_clk; analog comparators deliver levels
//
// Summary of operation
// (R1) no sink: gate off, converter off
// (R2) gate before soft-start, off after discharge
// (R3) system reset raises unconfigured alert
// (R4) converter off until setup-done written
// (R5) system enable low: standby, regulator off
// (R6) regulator needs enable and input supply
// (R7) permit is pin AND register bit
// (R8) pin variant: register bit always high
// (R9) low pin overrides register enable
// (R10) pin low at enable: wait for high
// (R11) clamp overvoltage disables data switches
// (R12) watch low-side on-time every cycle
// (R13) long minimum off-time forces low-side pulse
// (R14) output target from register, default 5.15V
// (R15) cable power on the spare CC pin
// (R16) cable power cut on overvoltage, overcurrent
// (R17) legacy adapter pulldown counts as attach
// (R18) host: clamp supply up before enable
// (R19) detach: converter off, wait retry interval
// (R20) permit low: converter waits retry interval
// (R21) setup-done clears on every system reset
`timescale 1ns/1ps
`default_nettype none
`include "pps_map.svh"

module pps_sequencer #(
	parameter bit REG_VARIANT = 1'b1,
	parameter int DETACH_RETRY_CYC = `PPS_US_CYC(`PPS_DETACH_RETRY_US),
	parameter int PERMIT_RETRY_CYC = `PPS_US_CYC(`PPS_PERMIT_RETRY_US),
	parameter int TMR_W = 20
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// register port
	input wire logic [`PPS_ADDR_W-1:0] reg_addr,
	input wire logic [`PPS_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`PPS_DATA_W-1:0] reg_rdata_ff,
	// enables and supply monitors
	input wire logic system_enable_pin,
	input wire logic converter_enable_pin,
	input wire logic input_supply_ok,
	input wire logic internal_supply_ok,
	input wire logic clamp_supply_ov,
	// configuration channel pulldown detectors
	input wire logic cc1_rd,
	input wire logic cc1_ra,
	input wire logic cc2_rd,
	input wire logic cc2_ra,
	// cable power source and switch monitors
	input wire logic cable_power_feed_ok,
	input wire logic cable_power_feed_ov,
	input wire logic cable_power_feed_oc,
	// converter feedback
	input wire logic discharge_done,
	input wire logic low_side_on,
	// power path controls
	output logic internal_regulator_on_ff,
	output logic converter_run_ff,
	output logic output_isolation_gate_ff,
	output logic output_discharge_ff,
	output logic low_side_force_ff,
	output logic [`PPS_VOUT_W-1:0] vout_target_ff,
	output logic data_switch_en_ff,
	output logic cable_power_feed_cc1_ff,
	output logic cable_power_feed_cc2_ff,
	// host side indications
	output logic host_alert_ff,
	output logic attach_ff,
	output logic polarity_ff
);
	localparam int MIN_OFF_CYC = `PPS_NS_CYC_UP(`PPS_MIN_OFF_NS);
	localparam int REFRESH_CYC = `PPS_NS_CYC_DN(`PPS_REFRESH_NS);
	localparam int FORCE_CYC = `PPS_NS_CYC_DN(`PPS_FORCE_NS);
	localparam int GATE_LEAD_CYC = `PPS_NS_CYC_UP(`PPS_GATE_LEAD_NS);

	// sink seen on this pin with no sink on the other one
	function automatic logic cc_sink(input logic this_rd, input logic other_rd);
		cc_sink = this_rd && !other_rd;
	endfunction

	logic rst_meta_ff;
	logic rst_sync_ff;
	logic sys_active;
	logic en_bit_ff;
	logic done_ff;
	logic pin_armed_ff;
	logic permit_ff;
	logic permit_now;
	logic configured;
	logic feed_fault_ff;
	logic det_busy;
	logic perm_busy;
	logic detach_ev;
	logic permit_fall;
	logic go_ok;
	logic feed_on;
	logic force_low;
	logic [7:0] gate_cnt_ff;
	logic [`PPS_DATA_W-1:0] nxt_rdata;
	pps_pkg::pps_cc_t cc_now;
	pps_pkg::pps_state_t state_ff;
	pps_pkg::pps_state_t nxt_state;

	// reset release through two flops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// internal circuitry runs only with enable, input supply and internal supply
	assign sys_active = system_enable_pin && input_supply_ok && internal_supply_ok; // [R5] [R6]

	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			internal_regulator_on_ff <= 1'b0;
		end else begin
			internal_regulator_on_ff <= system_enable_pin && input_supply_ok; // [R5] [R6]
		end
	end

	// attach decode; an adapter pulldown alone reads as a sink
	always_comb begin
		cc_now.sink_cc1 = cc_sink(cc1_rd, cc2_rd); // [R17]
		cc_now.sink_cc2 = cc_sink(cc2_rd, cc1_rd); // [R17]
		cc_now.attach = cc_now.sink_cc1 || cc_now.sink_cc2;
		cc_now.pol = cc_now.sink_cc1;
	end

	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			attach_ff <= 1'b0;
			polarity_ff <= 1'b0;
		end else begin
			attach_ff <= sys_active && cc_now.attach;
			polarity_ff <= sys_active && cc_now.pol;
		end
	end

	// control register: enable bit and setup-done
	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			en_bit_ff <= 1'b0;
			done_ff <= 1'b0;
		end else if (!sys_active) begin
			en_bit_ff <= 1'b0;
			done_ff <= 1'b0; // [R21]
		end else if (reg_wr && reg_addr == `PPS_REG_CTRL) begin
			en_bit_ff <= reg_wdata[`PPS_CTRL_EN_BIT];
			done_ff <= reg_wdata[`PPS_CTRL_DONE_BIT];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			vout_target_ff <= `PPS_VOUT_RST; // [R14]
		end else if (reg_wr && reg_addr == `PPS_REG_VOUT) begin
			vout_target_ff <= reg_wdata[`PPS_VOUT_W-1:0]; // [R14]
		end
	end

	// unconfigured alert: system reset sets it, setup-done write clears it
	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			host_alert_ff <= REG_VARIANT;
		end else if (REG_VARIANT && !sys_active) begin
			host_alert_ff <= 1'b1; // [R3]
		end else if (reg_wr && reg_addr == `PPS_REG_CTRL && reg_wdata[`PPS_CTRL_DONE_BIT]) begin
			host_alert_ff <= 1'b0;
		end
	end

	assign configured = REG_VARIANT ? done_ff : 1'b1; // [R4]

	// the enable pin must be seen high after each system start
	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			pin_armed_ff <= 1'b0;
		end else if (!sys_active) begin
			pin_armed_ff <= 1'b0; // [R10]
		end else if (converter_enable_pin) begin
			pin_armed_ff <= 1'b1; // [R10]
		end
	end

	// pin variant ties the register term high; a low pin always wins
	assign permit_now = sys_active && pin_armed_ff && converter_enable_pin
		&& (REG_VARIANT ? en_bit_ff : 1'b1); // [R7] [R8] [R9]

	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			permit_ff <= 1'b0;
		end else begin
			permit_ff <= permit_now; // [R7]
		end
	end

	assign detach_ev = attach_ff && !(sys_active && cc_now.attach);
	assign permit_fall = permit_ff && !permit_now;

	pps_retry_timer #(
		.W(TMR_W)
	) u_detach_tmr (
		.clk(ref_clk),
		.rst_n(rst_sync_ff),
		.load(detach_ev), // [R19]
		.load_val(TMR_W'(DETACH_RETRY_CYC)),
		.busy_ff(det_busy)
	);

	pps_retry_timer #(
		.W(TMR_W)
	) u_permit_tmr (
		.clk(ref_clk),
		.rst_n(rst_sync_ff),
		.load(permit_fall), // [R20]
		.load_val(TMR_W'(PERMIT_RETRY_CYC)),
		.busy_ff(perm_busy)
	);

	// everything that must hold for the port to be powered
	assign go_ok = sys_active && attach_ff && permit_ff && configured
		&& !det_busy && !perm_busy; // [R1] [R4] [R7] [R19] [R20]

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			pps_pkg::PPS_ST_OFF: begin
				if (sys_active) begin
					nxt_state = pps_pkg::PPS_ST_IDLE;
				end
			end
			pps_pkg::PPS_ST_IDLE: begin
				if (!sys_active) begin
					nxt_state = pps_pkg::PPS_ST_OFF; // [R5]
				end else if (go_ok) begin
					nxt_state = pps_pkg::PPS_ST_GATE; // [R2]
				end
			end
			pps_pkg::PPS_ST_GATE: begin
				if (!go_ok) begin
					nxt_state = pps_pkg::PPS_ST_DISCH;
				end else if (gate_cnt_ff == 8'(GATE_LEAD_CYC - 1)) begin
					nxt_state = pps_pkg::PPS_ST_RUN; // [R2]
				end
			end
			pps_pkg::PPS_ST_RUN: begin
				if (!go_ok) begin
					nxt_state = pps_pkg::PPS_ST_DISCH; // [R1] [R19] [R20]
				end
			end
			pps_pkg::PPS_ST_DISCH: begin
				if (discharge_done) begin
					nxt_state = sys_active ? pps_pkg::PPS_ST_IDLE : pps_pkg::PPS_ST_OFF; // [R2]
				end
			end
			default: begin
				nxt_state = pps_pkg::PPS_ST_OFF;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			state_ff <= pps_pkg::PPS_ST_OFF;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			gate_cnt_ff <= '0;
		end else if (state_ff == pps_pkg::PPS_ST_GATE) begin
			gate_cnt_ff <= gate_cnt_ff + 8'h01;
		end else begin
			gate_cnt_ff <= '0;
		end
	end

	// gate leads the converter and trails the discharge
	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			converter_run_ff <= 1'b0;
			output_isolation_gate_ff <= 1'b0;
			output_discharge_ff <= 1'b0;
		end else begin
			converter_run_ff <= (nxt_state == pps_pkg::PPS_ST_RUN); // [R1] [R4]
			output_isolation_gate_ff <= (nxt_state == pps_pkg::PPS_ST_GATE)
				|| (nxt_state == pps_pkg::PPS_ST_RUN)
				|| (nxt_state == pps_pkg::PPS_ST_DISCH); // [R1] [R2]
			output_discharge_ff <= (nxt_state == pps_pkg::PPS_ST_DISCH); // [R2]
		end
	end

	pps_dropout_refresh #(
		.MIN_OFF_CYC(MIN_OFF_CYC),
		.WINDOW_CYC(REFRESH_CYC),
		.FORCE_CYC(FORCE_CYC)
	) u_dropout (
		.clk(ref_clk),
		.rst_n(rst_sync_ff),
		.active(converter_run_ff), // [R12]
		.low_side_on(low_side_on),
		.force_ff(force_low)
	);

	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			low_side_force_ff <= 1'b0;
		end else begin
			low_side_force_ff <= force_low && (nxt_state == pps_pkg::PPS_ST_RUN); // [R13]
		end
	end

	// data switches follow the clamp supply lockout
	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			data_switch_en_ff <= 1'b0;
		end else begin
			data_switch_en_ff <= sys_active && !clamp_supply_ov; // [R11]
		end
	end

	// cable power fault latch; a new fault wins over the detach clear
	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			feed_fault_ff <= 1'b0;
		end else if (cable_power_feed_ov || cable_power_feed_oc) begin
			feed_fault_ff <= 1'b1; // [R16]
		end else if (!attach_ff) begin
			feed_fault_ff <= 1'b0;
		end
	end

	assign feed_on = (nxt_state == pps_pkg::PPS_ST_RUN) && cable_power_feed_ok && !feed_fault_ff
		&& !cable_power_feed_ov && !cable_power_feed_oc; // [R15] [R16]

	// feed goes to the pin that carries the cable pulldown, not the sink wire
	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			cable_power_feed_cc1_ff <= 1'b0;
			cable_power_feed_cc2_ff <= 1'b0;
		end else begin
			cable_power_feed_cc1_ff <= feed_on && cc_now.sink_cc2 && cc1_ra; // [R15]
			cable_power_feed_cc2_ff <= feed_on && cc_now.sink_cc1 && cc2_ra; // [R15]
		end
	end

	// read data stand for one cycle only
	always_comb begin
		nxt_rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				`PPS_REG_CTRL: begin
					nxt_rdata[`PPS_CTRL_EN_BIT] = en_bit_ff;
					nxt_rdata[`PPS_CTRL_DONE_BIT] = done_ff;
				end
				`PPS_REG_VOUT: begin
					nxt_rdata[`PPS_VOUT_W-1:0] = vout_target_ff;
				end
				`PPS_REG_STATUS: begin
					nxt_rdata[11:0] = {state_ff, feed_fault_ff, det_busy, perm_busy,
						permit_ff, host_alert_ff, polarity_ff, attach_ff,
						data_switch_en_ff, converter_run_ff};
				end
				default: begin
					nxt_rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			reg_rdata_ff <= '0;
		end else begin
			reg_rdata_ff <= nxt_rdata;
		end
	end
endmodule // pps_sequencer

`default_nettype wire

/* verification/pps_sink_model.sv */
// attached sink, optional powered cable, and the output sense node
// assumes clk is ref_clk of the sequencer under test
`timescale 1ns/1ps
`default_nettype none

module pps_sink_model (
	// clock
	input wire logic clk,
	// bench controls
	input wire logic attach,
	input wire logic orient,
	input wire logic cable,
	// sequencer side
	input wire logic discharge,
	output logic cc1_rd,
	output logic cc1_ra,
	output logic cc2_rd,
	output logic cc2_ra,
	output logic discharge_done
);
	logic [3:0] dis_cnt_ff;

	// sink or legacy adapter pulldown on one pin, cable pulldown on the other
	assign cc1_rd = attach & orient;
	assign cc2_rd = attach & ~orient;
	assign cc1_ra = attach & cable & ~orient;
	assign cc2_ra = attach & cable & orient;

	// node needs several cycles of discharge before it reads empty
	always_ff @(posedge clk) begin
		dis_cnt_ff <= !discharge ? 4'h0 : (dis_cnt_ff == 4'hf ? dis_cnt_ff : dis_cnt_ff + 4'h1);
	end
	assign discharge_done = dis_cnt_ff >= 4'h6;
endmodule // pps_sink_model

`default_nettype wire

/* verification/pps_sequencer_chk.sv */
// port-level checks of the port power enable sequencer
// assumes the reset copy inside the design lags rst_n by two edges
`timescale 1ns/1ps
`default_nettype none

module pps_sequencer_chk (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// inputs watched
	input wire logic system_enable_pin,
	input wire logic converter_enable_pin,
	input wire logic input_supply_ok,
	input wire logic clamp_supply_ov,
	input wire logic cable_power_feed_ov,
	input wire logic cable_power_feed_oc,
	input wire logic discharge_done,
	// outputs watched
	input wire logic internal_regulator_on_ff,
	input wire logic converter_run_ff,
	input wire logic output_isolation_gate_ff,
	input wire logic low_side_force_ff,
	input wire logic data_switch_en_ff,
	input wire logic cable_power_feed_cc1_ff,
	input wire logic cable_power_feed_cc2_ff,
	input wire logic host_alert_ff,
	input wire logic attach_ff,
	input wire logic polarity_ff
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	a_unconf_conv_off: assert property (host_alert_ff && $past(host_alert_ff, 3) |-> !converter_run_ff)
		else $error("converter runs while unconfigured");
	a_gate_lead_run: assert property ($rose(converter_run_ff) |-> output_isolation_gate_ff
		&& $past(output_isolation_gate_ff, 10))
		else $error("converter started without gate lead");
	a_gate_after_dis: assert property ($fell(output_isolation_gate_ff) |-> $past(discharge_done)
		&& !converter_run_ff)
		else $error("gate dropped before discharge");
	a_detach_conv_stop: assert property ($fell(attach_ff) |-> ##[1:3] !converter_run_ff)
		else $error("converter kept running after detach");
	a_pin_conv_stop: assert property (!converter_enable_pin |-> ##[1:4] !converter_run_ff)
		else $error("converter ran with enable pin low");
	a_run_needs_pin: assert property ($rose(converter_run_ff) |-> converter_enable_pin && attach_ff)
		else $error("converter started without permit");
	a_standby_reg_off: assert property (!system_enable_pin |-> ##[1:4] !internal_regulator_on_ff)
		else $error("regulator on in standby");
	a_reg_start_cond: assert property ($rose(internal_regulator_on_ff) |-> $past(system_enable_pin)
		&& $past(input_supply_ok))
		else $error("regulator started without enable and supply");
	a_clamp_data_off: assert property (clamp_supply_ov ##1 clamp_supply_ov |=> !data_switch_en_ff)
		else $error("data switches on during clamp overvoltage");
	a_feed_spare_pin: assert property (cable_power_feed_cc1_ff |-> !polarity_ff)
		else $error("cable power on the channel pin");
	a_feed_fault_cut: assert property ((cable_power_feed_ov || cable_power_feed_oc) |=>
		!cable_power_feed_cc1_ff && !cable_power_feed_cc2_ff)
		else $error("cable power kept during fault");
	a_force_pulse_len: assert property ($rose(low_side_force_ff) |-> low_side_force_ff[*3]
		##1 !low_side_force_ff)
		else $error("forced low-side pulse length wrong");

	c_run: cover property ($rose(converter_run_ff));
	c_force: cover property ($rose(low_side_force_ff));
	c_feed: cover property (cable_power_feed_cc1_ff || cable_power_feed_cc2_ff);
	c_gate_off: cover property ($fell(output_isolation_gate_ff));
endmodule // pps_sequencer_chk

bind pps_sequencer pps_sequencer_chk i_chk (.*);

`default_nettype wire

/* verification/tb_port_power_enable_sequencer.sv */
// self-checking bench for the port power enable sequencer
// assumes retry intervals shortened to 20 cycles and a 50 MHz ref_clk
`timescale 1ns/1ps
`default_nettype none

module tb_port_power_enable_sequencer;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata_ff;
	logic sys_en = 1'b1;
	logic pin = 1'b1;
	logic sup_ok = 1'b1;
	logic int_ok = 1'b1;
	logic clamp_ov = 1'b0; // clamp supply settled before enable
	logic feed_ok = 1'b0;
	logic feed_ov = 1'b0;
	logic feed_oc = 1'b0;
	logic low_side_on = 1'b0;
	logic snk_att = 1'b0;
	logic snk_ori = 1'b0;
	logic ls_en = 1'b0;
	logic cc1_rd, cc1_ra, cc2_rd, cc2_ra, dis_done;
	logic reg_on, run, gate, dis, force_o, ds_en, f1, f2, alert, att, pol;
	logic [9:0] vout;
	logic [5:0] o;
	logic [31:0] v;
	logic [31:0] vr;
	int num_errors = 0;
	int checks_done = 0;
	int cyc = 0;

	pps_sequencer #(.DETACH_RETRY_CYC(20), .PERMIT_RETRY_CYC(20)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
		.system_enable_pin(sys_en), .converter_enable_pin(pin), .input_supply_ok(sup_ok),
		.internal_supply_ok(int_ok), .clamp_supply_ov(clamp_ov), .cc1_rd(cc1_rd), .cc1_ra(cc1_ra),
		.cc2_rd(cc2_rd), .cc2_ra(cc2_ra), .cable_power_feed_ok(feed_ok), .cable_power_feed_ov(feed_ov),
		.cable_power_feed_oc(feed_oc), .discharge_done(dis_done), .low_side_on(low_side_on),
		.internal_regulator_on_ff(reg_on), .converter_run_ff(run), .output_isolation_gate_ff(gate),
		.output_discharge_ff(dis), .low_side_force_ff(force_o), .vout_target_ff(vout),
		.data_switch_en_ff(ds_en), .cable_power_feed_cc1_ff(f1), .cable_power_feed_cc2_ff(f2),
		.host_alert_ff(alert), .attach_ff(att), .polarity_ff(pol));

	pps_sink_model i_sink (.clk(ref_clk), .attach(snk_att), .orient(snk_ori), .cable(1'b1),
		.discharge(dis), .cc1_rd(cc1_rd), .cc1_ra(cc1_ra), .cc2_rd(cc2_rd), .cc2_ra(cc2_ra),
		.discharge_done(dis_done));

	assign o = {alert, ds_en, f1 | f2, force_o, gate, run};

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	// short low-side on-times each switching period while enabled
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		low_side_on <= ls_en && (cyc % 10 < 4);
		if (cyc == 20000) begin
			num_errors++;
			test_done();
		end
	end

	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 r = reg_rdata_ff;
	endtask

	task automatic wait_for(input string nm, input int k, input logic e, input int n);
		int i;
		for (i = 0; i < n && o[k] !== e; i++) @(posedge ref_clk) #1;
		chk(nm, {31'h0, e}, {31'h0, o[k]});
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	initial begin
		void'($urandom(67119));
		cycles(20);
		rst_n <= 1'b1;
		cycles(3);
		chk("vout reset", 32'h203, {22'h0, vout});
		chk("alert reset", 1, alert);
		@(posedge ref_clk);
		snk_ori <= $urandom % 2;
		snk_att <= 1'b1;
		feed_ok <= 1'b1;
		cycles(40);
		chk("run unconfigured", 0, run);
		chk("polarity", snk_ori, pol);
		chk("attach", 1, att);
		wr(8'h00, 32'h3);
		wait_for("alert clear", 5, 1'b0, 3);
		wait_for("gate on", 1, 1'b1, 10);
		chk("run before lead", 0, run);
		wait_for("run on", 0, 1'b1, 20);
		rd(8'h08, v);
		chk("status run", 32'h601, v & 32'he01);
		cycles(3);
		chk("feed cc1", !snk_ori, f1);
		chk("feed cc2", snk_ori, f2);
		vr = $urandom & 32'h3ff;
		wr(8'h04, vr);
		rd(8'h04, v);
		chk("vout read", vr, v);
		chk("vout port", vr, {22'h0, vout});
		wr(8'h0c, 32'hffffffff);
		rd(8'h0c, v);
		chk("unmapped", 0, v);
		@(posedge ref_clk);
		ls_en <= 1'b1;
		wait_for("dropout force", 2, 1'b1, 1000);
		@(posedge ref_clk);
		ls_en <= 1'b0;
		feed_ov <= 1'b1;
		cycles(2);
		chk("feed ov cut", 0, f1 | f2);
		feed_ov <= 1'b0;
		cycles(3);
		chk("feed latched", 0, f1 | f2);
		clamp_ov <= 1'b1;
		cycles(3);
		chk("data switch ov", 0, ds_en);
		clamp_ov <= 1'b0;
		pin <= 1'b0;
		wait_for("pin stop", 0, 1'b0, 5);
		chk("gate in discharge", 1, gate);
		chk("discharge on", 1, dis);
		wait_for("gate off", 1, 1'b0, 30);
		pin <= 1'b1;
		cycles(4);
		chk("permit retry", 0, gate);
		wait_for("run again", 0, 1'b1, 80);
		snk_att <= 1'b0;
		wait_for("detach stop", 0, 1'b0, 4);
		wait_for("detach gate", 1, 1'b0, 30);
		snk_att <= 1'b1;
		cycles(4);
		chk("detach retry", 0, gate);
		wait_for("reattach run", 0, 1'b1, 80);
		cycles(3);
		chk("feed restored", !snk_ori, f1);
		pin <= 1'b0;
		sys_en <= 1'b0;
		cycles(4);
		chk("standby regulator", 0, reg_on);
		sys_en <= 1'b1;
		cycles(4);
		chk("alert after reset", 1, alert);
		rd(8'h00, v);
		chk("ctrl cleared", 0, v);
		wr(8'h00, 32'h3);
		cycles(40);
		chk("pin low at enable", 0, run);
		pin <= 1'b1;
		wait_for("pin high run", 0, 1'b1, 80);
		sup_ok <= 1'b0;
		cycles(4);
		chk("supply lockout", 0, reg_on);
		sup_ok <= 1'b1;
		int_ok <= 1'b0;
		cycles(4);
		chk("internal lockout", 0, run);
		int_ok <= 1'b1;
		cycles(4);
		chk("alert after lockout", 1, alert);
		test_done();
	end
endmodule // tb_port_power_enable_sequencer

`default_nettype wire
